// ===== hdl/hub_cfg_defines.svh
// Offsets, field positions, reset values and timing counts of the block
//
// Contract
// - Nonzero product string length returns stored bytes for string index 2.
// - Descriptor carries product string length bytes, capped at PSTR_BYTES (64 by default).
// - Product string bytes are byte registers at 90h-CFh, reset zero.
// - Feature bit 4 gates the four hub status outputs.
// - Feature bit 0 set turns PLL spread spectrum off.
// - EEPROM load or later SMBus write; the most recent write wins.
// - Feature configuration register sits at offset F0h.
`ifndef HUB_CFG_DEFINES_SVH
`define HUB_CFG_DEFINES_SVH

`define PSTR_FIRST_OFS 8'h90
`define PSTR_LAST_OFS 8'hCF
`define FEAT_CFG_OFS 8'hF0
`define FEAT_CFG_RESET 8'h00
`define PSTR_RESET 8'h00
`define FEAT_SPREAD_DIS_BIT 0
`define FEAT_PWRON_LSB 1
`define FEAT_PWRON_MSB 3
`define FEAT_STS_EN_BIT 4
`define FEAT_RSVD_LSB 5
`define FEAT_RSVD_MSB 7
`define PSTR_STRING_INDEX 8'h02
`define PWRON_STEP_MS 200
`define CLK_MHZ 100
`define PWRON_STEP_CYCLES (`PWRON_STEP_MS * 1000 * `CLK_MHZ)

`endif

// ===== hdl/hub_cfg_pkg.sv
// Types shared by the configuration slice
package hub_cfg_pkg;
  typedef enum logic [1:0] {
    PWR_IDLE,
    PWR_WAIT,
    PWR_ON
  } pwr_state_e;

  typedef enum logic [1:0] {
    DSC_IDLE,
    DSC_SEND
  } dsc_state_e;
endpackage

// ===== hdl/hub_product_string_feature_cfg.sv
// Product string bytes, feature configuration and their effects
`timescale 1ns/1ps
`include "hub_cfg_defines.svh"
module hub_product_string_feature_cfg #(
  parameter int PSTR_BYTES = 64,
  parameter int STEP_CYCLES = `PWRON_STEP_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic SRST,
  // Configuration write/read port from EEPROM loader or SMBus slave
  input wire logic CFG_WR,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [7:0] CFG_WDATA,
  output logic [7:0] CFG_RDATA,
  input wire logic [7:0] PRODUCT_STRING_LENGTH,
  // Descriptor byte stream for string requests
  input wire logic DESC_REQ,
  input wire logic [7:0] DESC_INDEX,
  input wire logic DESC_READY,
  output logic DESC_VALID,
  output logic [7:0] DESC_DATA,
  output logic DESC_LAST,
  output logic DESC_NOT_OURS,
  // Link state from the hub core
  input wire logic HIGH_SPEED_LINK_UP_OUT_IN,
  input wire logic HS_SUSP_IN,
  input wire logic SS_UP_IN,
  input wire logic SS_SUSP_IN,
  output logic HIGH_SPEED_LINK_UP_OUT,
  output logic HIGH_SPEED_SUSPENDED_OUT,
  output logic SUPERSPEED_LINK_UP_OUT,
  output logic SUPERSPEED_SUSPENDED_OUT,
  // Battery charging transition handshake
  input wire logic BC_TRANSITION,
  output logic PORT_POWER_SWITCH_CONTROL,
  output logic POWER_ON_BUSY,
  output logic PLL_SPREAD_SPECTRUM_DISABLE
);
  if (PSTR_BYTES < 1 || PSTR_BYTES > 64) begin : g_bad_bytes
    $error("PSTR_BYTES must be 1..64");
  end
  if (STEP_CYCLES < 1) begin : g_bad_step
    $error("STEP_CYCLES must be at least 1");
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] product_string_octet_r [PSTR_BYTES];
  logic [7:0] product_string_octet_nxt [PSTR_BYTES];
  logic [7:0] feat_r;
  logic [7:0] feat_nxt;

  function automatic logic in_pstr(input logic [7:0] a);
    in_pstr = (a >= `PSTR_FIRST_OFS) &&
              (a < `PSTR_FIRST_OFS + 8'(PSTR_BYTES));
  endfunction

  always_comb begin
    for (int i = 0; i < PSTR_BYTES; i++) begin
      product_string_octet_nxt[i] = product_string_octet_r[i];
      if (CFG_WR && in_pstr(CFG_ADDR) &&
          (CFG_ADDR - `PSTR_FIRST_OFS) == 8'(i)) begin
        product_string_octet_nxt[i] = CFG_WDATA;
      end
    end
    feat_nxt = feat_r;
    if (CFG_WR && CFG_ADDR == `FEAT_CFG_OFS) begin
      feat_nxt = CFG_WDATA;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      for (int i = 0; i < PSTR_BYTES; i++) begin
        product_string_octet_r[i] <= `PSTR_RESET;
      end
      feat_r <= `FEAT_CFG_RESET;
    end else begin
      product_string_octet_r <= product_string_octet_nxt;
      feat_r <= feat_nxt;
    end
  end

  logic [7:0] rdata_nxt;
  always_comb begin
    rdata_nxt = 8'h00;
    if (in_pstr(CFG_ADDR)) begin
      rdata_nxt = product_string_octet_r[6'(CFG_ADDR - `PSTR_FIRST_OFS)];
    end else if (CFG_ADDR == `FEAT_CFG_OFS) begin
      rdata_nxt = feat_r;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      CFG_RDATA <= 8'h00;
    end else begin
      CFG_RDATA <= rdata_nxt;
    end
  end

  logic status_output_enable;
  logic [2:0] power_on_delay_setting;
  assign status_output_enable = feat_r[`FEAT_STS_EN_BIT];
  assign power_on_delay_setting = feat_r[`FEAT_PWRON_MSB:`FEAT_PWRON_LSB];

  // ----------------------------------------
  // Status outputs and spread spectrum
  // ----------------------------------------
  logic [3:0] sts_nxt;
  logic [3:0] sts_r;
  logic spread_r;
  always_comb begin
    sts_nxt = 4'h0;
    if (status_output_enable) begin
      sts_nxt = {SS_SUSP_IN, SS_UP_IN, HS_SUSP_IN, HIGH_SPEED_LINK_UP_OUT_IN};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      sts_r <= 4'h0;
      spread_r <= 1'b0;
    end else begin
      sts_r <= sts_nxt;
      spread_r <= feat_r[`FEAT_SPREAD_DIS_BIT];
    end
  end

  assign HIGH_SPEED_LINK_UP_OUT = sts_r[0];
  assign HIGH_SPEED_SUSPENDED_OUT = sts_r[1];
  assign SUPERSPEED_LINK_UP_OUT = sts_r[2];
  assign SUPERSPEED_SUSPENDED_OUT = sts_r[3];
  assign PLL_SPREAD_SPECTRUM_DISABLE = spread_r;

  // ----------------------------------------
  // Power-on enable delay
  // ----------------------------------------
  hub_cfg_pkg::pwr_state_e pwr_r;
  hub_cfg_pkg::pwr_state_e pwr_nxt;
  logic [31:0] tick_r;
  logic [31:0] tick_nxt;
  logic [2:0] steps_r;
  logic [2:0] steps_nxt;

  always_comb begin
    pwr_nxt = pwr_r;
    tick_nxt = tick_r;
    steps_nxt = steps_r;
    unique case (pwr_r)
      hub_cfg_pkg::PWR_IDLE: begin
        if (BC_TRANSITION) begin
          pwr_nxt = (power_on_delay_setting == 3'h0) ?
                    hub_cfg_pkg::PWR_ON : hub_cfg_pkg::PWR_WAIT;
          steps_nxt = power_on_delay_setting;
          tick_nxt = 32'h0;
        end
      end
      hub_cfg_pkg::PWR_WAIT: begin
        if (tick_r == 32'(STEP_CYCLES - 1)) begin
          tick_nxt = 32'h0;
          steps_nxt = steps_r - 3'h1;
          if (steps_r == 3'h1) begin
            pwr_nxt = hub_cfg_pkg::PWR_ON;
          end
        end else begin
          tick_nxt = tick_r + 32'h1;
        end
      end
      hub_cfg_pkg::PWR_ON: begin
        if (BC_TRANSITION) begin
          pwr_nxt = hub_cfg_pkg::PWR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      pwr_r <= hub_cfg_pkg::PWR_IDLE;
      tick_r <= 32'h0;
      steps_r <= 3'h0;
    end else begin
      pwr_r <= pwr_nxt;
      tick_r <= tick_nxt;
      steps_r <= steps_nxt;
    end
  end

  assign PORT_POWER_SWITCH_CONTROL = (pwr_r == hub_cfg_pkg::PWR_ON);
  assign POWER_ON_BUSY = (pwr_r == hub_cfg_pkg::PWR_WAIT);

  // ----------------------------------------
  // Product string descriptor stream
  // ----------------------------------------
  hub_cfg_pkg::dsc_state_e dsc_r;
  hub_cfg_pkg::dsc_state_e dsc_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic [7:0] len_r;
  logic [7:0] len_nxt;
  logic not_ours_nxt;
  logic not_ours_r;
  logic [7:0] dout_r;
  logic [7:0] dout_nxt;

  always_comb begin
    dsc_nxt = dsc_r;
    ptr_nxt = ptr_r;
    len_nxt = len_r;
    not_ours_nxt = 1'b0;
    dout_nxt = 8'h00;
    unique case (dsc_r)
      hub_cfg_pkg::DSC_IDLE: begin
        if (DESC_REQ) begin
          if (DESC_INDEX == `PSTR_STRING_INDEX &&
              PRODUCT_STRING_LENGTH != 8'h00) begin
            dsc_nxt = hub_cfg_pkg::DSC_SEND;
            ptr_nxt = 8'h00;
            len_nxt = (PRODUCT_STRING_LENGTH > 8'(PSTR_BYTES)) ?
                      8'(PSTR_BYTES) : PRODUCT_STRING_LENGTH;
          end else begin
            not_ours_nxt = 1'b1;
          end
        end
      end
      hub_cfg_pkg::DSC_SEND: begin
        if (DESC_READY) begin
          ptr_nxt = ptr_r + 8'h01;
          if (ptr_r == len_r - 8'h01) begin
            dsc_nxt = hub_cfg_pkg::DSC_IDLE;
          end
        end
      end
    endcase
    // Next byte is registered so the data output comes from a flop
    if (dsc_nxt == hub_cfg_pkg::DSC_SEND) begin
      dout_nxt = product_string_octet_r[6'(ptr_nxt)];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      dsc_r <= hub_cfg_pkg::DSC_IDLE;
      ptr_r <= 8'h00;
      len_r <= 8'h00;
      not_ours_r <= 1'b0;
      dout_r <= 8'h00;
    end else begin
      dsc_r <= dsc_nxt;
      ptr_r <= ptr_nxt;
      len_r <= len_nxt;
      not_ours_r <= not_ours_nxt;
      dout_r <= dout_nxt;
    end
  end

  assign DESC_VALID = (dsc_r == hub_cfg_pkg::DSC_SEND);
  assign DESC_DATA = dout_r;
  assign DESC_LAST = DESC_VALID && (ptr_r == len_r - 8'h01);
  assign DESC_NOT_OURS = not_ours_r;
endmodule

// ===== tb/hub_cfg_sva.sv
// Port assertions for the configuration slice
`timescale 1ns/1ps
module hub_cfg_sva (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic CFG_WR,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [7:0] CFG_WDATA,
  input wire logic [7:0] PRODUCT_STRING_LENGTH,
  input wire logic DESC_REQ,
  input wire logic [7:0] DESC_INDEX,
  input wire logic DESC_READY,
  input wire logic DESC_VALID,
  input wire logic [7:0] DESC_DATA,
  input wire logic DESC_LAST,
  input wire logic DESC_NOT_OURS,
  input wire logic HIGH_SPEED_LINK_UP_OUT_IN,
  input wire logic SS_SUSP_IN,
  input wire logic HIGH_SPEED_LINK_UP_OUT,
  input wire logic SUPERSPEED_SUSPENDED_OUT,
  input wire logic PORT_POWER_SWITCH_CONTROL,
  input wire logic POWER_ON_BUSY,
  input wire logic PLL_SPREAD_SPECTRUM_DISABLE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  sequence s_feat_wr;
    CFG_WR && CFG_ADDR == 8'hF0 ##1 !CFG_WR;
  endsequence
  sequence s_req;
    DESC_REQ && !DESC_VALID;
  endsequence
  high_speed_link_up_out_gate_a: assert property (
    HIGH_SPEED_LINK_UP_OUT |-> $past(HIGH_SPEED_LINK_UP_OUT_IN)) else $error("high_speed_link_up_out leak");
  ss_susp_gate_a: assert property (
    SUPERSPEED_SUSPENDED_OUT |-> $past(SS_SUSP_IN)) else $error("ss susp leak");
  foreign_req_a: assert property (
    s_req ##0 (DESC_INDEX != 8'h02 || PRODUCT_STRING_LENGTH == 8'h00)
    |=> DESC_NOT_OURS) else $error("foreign request not flagged");
  own_req_a: assert property (
    s_req ##0 (DESC_INDEX == 8'h02 && PRODUCT_STRING_LENGTH != 8'h00)
    |=> DESC_VALID && !DESC_NOT_OURS) else $error("own request not sent");
  byte_hold_a: assert property (
    DESC_VALID && !DESC_READY |=> DESC_VALID && $stable(DESC_DATA)
    && $stable(DESC_LAST)) else $error("byte dropped while stalled");
  last_drop_a: assert property (
    DESC_VALID && DESC_READY && DESC_LAST |=> !DESC_VALID)
    else $error("valid after last byte");
  power_ready_a: assert property (
    $fell(POWER_ON_BUSY) |-> PORT_POWER_SWITCH_CONTROL)
    else $error("delay ended without enable");
  spread_copy_a: assert property (
    s_feat_wr |=> PLL_SPREAD_SPECTRUM_DISABLE == $past(CFG_WDATA[0], 2))
    else $error("spread disable mismatch");
endmodule
bind hub_product_string_feature_cfg hub_cfg_sva chk (.*);

// ===== tb/cfg_host_model.sv
// Configuration writer standing in for an EEPROM loader or bus host
`timescale 1ns/1ps
module cfg_host_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic wr,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  initial begin
    wr = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = (a == 8'hF0) ? (d & 8'h1F) : d;
    @(negedge clk);
    wr = 1'b0;
    wdata = ~wdata;
  endtask
  task automatic put_char(input int i, input logic [15:0] c);
    put(8'h90 + 8'(2 * i), c[7:0]);
    put(8'h91 + 8'(2 * i), c[15:8]);
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    repeat (2) @(negedge clk);
    d = rdata;
  endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench for the configuration slice
`timescale 1ns/1ps
module tb;
  typedef struct {logic [7:0] f; logic [3:0] li, lo; int dly;} row_s;
  logic clk, srst, dreq, drdy, dval, dlast, dno, bc, ctrl, busy, pll, wr;
  logic [7:0] addr, wdata, rdata, plen, didx, ddata, d;
  logic [3:0] lin, lout;
  int n_fail, total_checks, cyc, k;
  row_s rows[5] = '{'{8'h00, 4'hF, 4'h0, 0}, '{8'h10, 4'hA, 4'hA, 0},
    '{8'h11, 4'h5, 4'h5, 0}, '{8'h02, 4'hF, 4'h0, 4},
    '{8'h1E, 4'h3, 4'h3, 28}};
  cfg_host_model host (.clk(clk), .rdata(rdata), .wr(wr), .addr(addr),
    .wdata(wdata));
  hub_product_string_feature_cfg #(.STEP_CYCLES(4)) uut (.CORE_CLK(clk),
    .SRST(srst), .CFG_WR(wr), .CFG_ADDR(addr), .CFG_WDATA(wdata),
    .CFG_RDATA(rdata), .PRODUCT_STRING_LENGTH(plen), .DESC_REQ(dreq),
    .DESC_INDEX(didx), .DESC_READY(drdy), .DESC_VALID(dval),
    .DESC_DATA(ddata), .DESC_LAST(dlast), .DESC_NOT_OURS(dno),
    .HIGH_SPEED_LINK_UP_OUT_IN(lin[3]), .HS_SUSP_IN(lin[2]), .SS_UP_IN(lin[1]),
    .SS_SUSP_IN(lin[0]), .HIGH_SPEED_LINK_UP_OUT(lout[3]),
    .HIGH_SPEED_SUSPENDED_OUT(lout[2]), .SUPERSPEED_LINK_UP_OUT(lout[1]),
    .SUPERSPEED_SUSPENDED_OUT(lout[0]), .BC_TRANSITION(bc),
    .PORT_POWER_SWITCH_CONTROL(ctrl), .POWER_ON_BUSY(busy),
    .PLL_SPREAD_SPECTRUM_DISABLE(pll));
  task automatic check(input string n, input logic [7:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    if (n_fail == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic desc(input logic [7:0] idx, input int n);
    @(negedge clk);
    dreq = 1'b1;
    didx = idx;
    @(negedge clk);
    dreq = 1'b0;
    check("not_ours", dno, n == 0);
    for (int j = 0; j < n; j++) begin
      k = 0;
      while (dval !== 1'b1 && k < 20) begin
        @(negedge clk);
        k++;
      end
      check("byte", ddata, j % 2 ? 8'h3A : 8'h40 + 8'(j / 2));
      check("last", dlast, j == n - 1);
      drdy = 1'b1;
      @(negedge clk);
      drdy = 1'b0;
      @(negedge clk);
    end
    check("done", dval, 8'h00);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      finish_test;
    end
  end
  // ----
  // Main sequence
  // ----
  initial begin
    {srst, dreq, drdy, bc, plen, didx, lin} = {4'h8, 20'h0};
    {n_fail, total_checks, cyc} = '0;
    repeat (12) @(posedge clk);
    @(negedge clk) srst = 1'b0;
    foreach (rows[i]) begin
      host.put(8'hF0, 8'hFF);
      host.put(8'hF0, rows[i].f);
      lin = rows[i].li;
      host.get(8'hF0, d);
      check("feat", d, rows[i].f);
      check("status", lout, rows[i].lo);
      check("spread", pll, rows[i].f[0]);
      bc = 1'b1;
      @(negedge clk);
      bc = 1'b0;
      check("busy", busy, rows[i].dly != 0);
      k = 0;
      while (ctrl !== 1'b1 && k < 40) begin
        @(negedge clk);
        k++;
      end
      check("busy_end", busy, 8'h00);
      check("delay", 8'(k), 8'(rows[i].dly));
      bc = 1'b1;
      @(negedge clk);
      bc = 1'b0;
    end
    for (int i = 0; i < 32; i++) host.put_char(i, 16'h3A40 + 16'(i));
    plen = 8'h05;
    desc(8'h02, 5);
    desc(8'h03, 0);
    plen = 8'h50;
    desc(8'h02, 64);
    plen = 8'h00;
    desc(8'h02, 0);
    host.get(8'hCF, d);
    check("top_byte", d, 8'h3A);
    host.get(8'h50, d);
    check("unmapped", d, 8'h00);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    host.get(8'h90, d);
    check("byte_rst", d, 8'h00);
    host.get(8'hF0, d);
    check("feat_rst", d, 8'h00);
    finish_test;
  end
endmodule
